// file: design/mux_regs_pkg.sv
// Register map, field positions and reset values of the control/status bank.
// Assumes a 32-bit APB slave port with byte addresses on word boundaries.
package mux_regs_pkg;

	// ****************************************
	// Register byte offsets
	// ****************************************
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFS_SYSTEM_CONTROL = 8'h00;
	localparam logic [7:0] OFS_LINE_CONTROL = 8'h04;
	localparam logic [7:0] OFS_STATUS_REPORT = 8'h08;
	localparam logic [7:0] OFS_RX_INT_CHAR = 8'h0c;
	localparam logic [7:0] OFS_SEC_REG_SELECT = 8'h10;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h14;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h18;

	// ****************************************
	// System control fields
	// ****************************************
	localparam int SC_GO = 0;
	localparam int SC_EXT_LO = 4;
	localparam int SC_RX_IE = 6;
	localparam int SC_RX_FLAG = 7;
	localparam int SC_RX_DONE = 8;
	localparam int SC_FLAG_WE = 9;
	localparam int SC_OVF = 10;
	localparam int SC_MCLR = 11;
	localparam int SC_OVF_IE = 12;
	localparam int SC_ST_IE = 13;
	localparam int SC_ST_FLAG = 15;
	// Bits a plain host write stores
	localparam logic [15:0] SC_RW_MASK = 16'h377f;
	// Bits a master clear forces to zero
	localparam logic [15:0] SC_MCLR_MASK = 16'hbecf;

	// ****************************************
	// Line control and select fields
	// ****************************************
	localparam int LC_EXT_LO = 4;
	localparam int LC_STORE_LO = 7;
	localparam int LC_STORE_HI = 14;
	localparam int LC_STROBE = 15;
	localparam int SRS_LINE_LO = 0;
	localparam int SRS_REG_LO = 8;
	localparam int NSR_TOP = 15;

	// ****************************************
	// Interrupt status bits, sizes, resets
	// ****************************************
	localparam int IRQ_ST = 0;
	localparam int IRQ_OVF = 1;
	localparam int IRQ_RX = 2;
	localparam int IRQ_W = 3;
	localparam int SILO_DEPTH = 64;
	localparam logic [15:0] REG_RESET = 16'h0000;
	localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;

endpackage : mux_regs_pkg

// file: design/word_ram.sv
// Small memory with one write port and a registered read port.
// Assumes read address is held steady by the caller; data lags one clock.
`timescale 1ns/100ps
`default_nettype none

module word_ram #(
	parameter int DEPTH = 256,
	parameter int WIDTH = 2
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// Write port
	input wire logic wr_en,
	input wire logic [$clog2(DEPTH)-1:0] wr_addr,
	input wire logic [WIDTH-1:0] wr_data,
	// Read port
	input wire logic [$clog2(DEPTH)-1:0] rd_addr,
	output logic [WIDTH-1:0] rd_data
);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [WIDTH-1:0] rd_r;
	} ram_s;

	ram_s s, s_nxt;

	// Next state: write then registered read of the stored word
	always_comb begin
		s_nxt = s;
		if (wr_en) begin
			s_nxt.mem[wr_addr] = wr_data;
		end
		s_nxt.rd_r = s.mem[rd_addr];
	end

	// Whole array clears on reset so reads are never unknown
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			s <= '0;
		end else begin
			s <= s_nxt;
		end
	end

	assign rd_data = s.rd_r;

endmodule : word_ram

`default_nettype wire

// file: design/status_silo.sv
// First-in first-out store for transmit status entries.
// Assumes DEPTH is a power of two; a push while full is dropped.
`timescale 1ns/100ps
`default_nettype none

module status_silo #(
	parameter int DEPTH = 64,
	parameter int WIDTH = 16
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// Filling side
	input wire logic push,
	input wire logic [WIDTH-1:0] push_data,
	// Draining side
	input wire logic pop,
	output logic [WIDTH-1:0] head_data,
	output logic empty,
	output logic full
);

	localparam int PW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW-1:0] wr_ptr;
		logic [PW-1:0] rd_ptr;
		logic [PW:0] count;
		logic [WIDTH-1:0] head_r;
		logic empty_r;
		logic full_r;
	} silo_s;

	silo_s s, s_nxt;
	logic do_push;
	logic do_pop;

	// Pointer and count update; head shows the oldest entry at once
	always_comb begin
		s_nxt = s;
		do_push = push & ~s.full_r;
		do_pop = pop & ~s.empty_r;
		if (do_push) begin
			s_nxt.mem[s.wr_ptr] = push_data;
		end
		s_nxt.wr_ptr = s.wr_ptr + PW'(do_push);
		s_nxt.rd_ptr = s.rd_ptr + PW'(do_pop);
		s_nxt.count = s.count + (PW+1)'(do_push) - (PW+1)'(do_pop);
		s_nxt.head_r = s_nxt.mem[s_nxt.rd_ptr];
		s_nxt.empty_r = (s_nxt.count == '0);
		s_nxt.full_r = (s_nxt.count == (PW+1)'(DEPTH));
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			s <= '0;
			s.empty_r <= 1'b1;
		end else begin
			s <= s_nxt;
		end
	end

	assign head_data = s.head_r;
	assign empty = s.empty_r;
	assign full = s.full_r;

endmodule : status_silo

`default_nettype wire

// file: design/mux_ctrl_regs.sv
// Control and status register bank of the multiplexer, reached over APB.
// Assumes the internal microprocessor drives its strobes synchronously
// to sys_clk, one cycle per event.
//
// Behaviour
// R1: Full status silo sets overflow flag
// R2: Overflow flag interrupts only when enabled
// R3: Overflow enable is read/write, reset clears
// R4: Master clear zeroes listed control bits
// R5: Master clear empties receive silo, self-clears
// R6: Status enable gates status flag interrupt
// R7: Each status entry sets status flag
// R8: Reading status report clears status flag
// R9: Status flag writable only with write enable
// R10: Line control bits 4-5 show extended address
// R11: Select register picks displayed secondary register
// R12: Receive flag writable only with write enable; a system control write with bit 8 set clears it without the enable
// R13: One vector B request for enabled conditions
`timescale 1ns/100ps
`default_nettype none

module mux_ctrl_regs
	import mux_regs_pkg::*;
#(
	parameter int DEPTH = SILO_DEPTH
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Microprocessor events
	input wire logic status_push,
	input wire logic [15:0] status_data,
	input wire logic rx_int_set,
	input wire logic ric_load,
	input wire logic [15:0] ric_data,
	// Extended address store
	input wire logic ext_wr,
	input wire logic [3:0] ext_wr_line,
	input wire logic [3:0] ext_wr_reg,
	input wire logic [1:0] ext_wr_bits,
	// Control outputs
	output logic uproc_go,
	output logic [1:0] ext_addr_hi,
	output logic [7:0] line_ctrl_bits,
	output logic line_strobe,
	output logic rx_silo_clear,
	// Interrupts
	output logic vector_a_req,
	output logic vector_b_req,
	output logic irq
);

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic [15:0] system_control_r;
		logic [15:0] line_control_r;
		logic [15:0] ric_r;
		logic [15:0] srs_r;
		logic [IRQ_W-1:0] irq_status_r;
		logic [IRQ_W-1:0] irq_mask_r;
		logic [IRQ_W-1:0] irq_seen_r;
		logic nsr_seen_r;
		logic nsr_hide_r;
		logic [31:0] prdata_r;
		logic pready_r;
		logic pslverr_r;
		logic strobe_r;
		logic rx_clr_r;
		logic vec_a_r;
		logic vec_b_r;
		logic irq_r;
	} regs_s;

	regs_s s, s_nxt;

	logic [15:0] silo_head;
	logic silo_empty;
	logic silo_full;
	logic silo_pop;
	logic [1:0] ext_rd_bits;
	logic [7:0] ext_rd_addr;

	// ****************************************
	// Storage blocks
	// ****************************************

	// Transmit status entries queued for the host
	status_silo #(
		.DEPTH(DEPTH),
		.WIDTH(16)
	) u_silo (
		.sys_clk(sys_clk),
		.reset(reset),
		.push(status_push),
		.push_data(status_data),
		.pop(silo_pop),
		.head_data(silo_head),
		.empty(silo_empty),
		.full(silo_full)
	);

	// Displayed register is picked by line and register select fields
	assign ext_rd_addr = {s.srs_r[SRS_REG_LO +: 4], s.srs_r[SRS_LINE_LO +: 4]}; // R11

	// Bits 16-17 of every secondary register, line by register
	word_ram #(
		.DEPTH(256),
		.WIDTH(2)
	) u_ext (
		.sys_clk(sys_clk),
		.reset(reset),
		.wr_en(ext_wr),
		.wr_addr({ext_wr_reg, ext_wr_line}),
		.wr_data(ext_wr_bits),
		.rd_addr(ext_rd_addr),
		.rd_data(ext_rd_bits)
	);

	// ****************************************
	// Bus decode
	// ****************************************
	logic in_access;
	logic commit;
	logic wr_commit;
	logic rd_commit;
	logic hit;
	logic [15:0] rd_word;

	// One wait state: read data settles before pready rises
	assign in_access = psel & penable & ~s.pready_r;
	assign commit = psel & penable & s.pready_r;
	assign wr_commit = commit & pwrite;
	assign rd_commit = commit & ~pwrite;

	// Read multiplexer, sampled in the first access cycle
	always_comb begin
		hit = 1'b1;
		rd_word = 16'h0000;
		case (paddr)
			OFS_SYSTEM_CONTROL: begin
				rd_word = s.system_control_r;
			end
			OFS_LINE_CONTROL: begin
				rd_word[LC_EXT_LO +: 2] = ext_rd_bits; // R10
			end
			OFS_STATUS_REPORT: begin
				rd_word = silo_empty ? 16'h0000 : silo_head;
				if (s.nsr_hide_r) begin
					rd_word[NSR_TOP] = 1'b0;
				end
			end
			OFS_RX_INT_CHAR: begin
				rd_word = s.ric_r;
			end
			OFS_SEC_REG_SELECT: begin
				rd_word = s.srs_r;
			end
			OFS_IRQ_STATUS: begin
				rd_word[IRQ_W-1:0] = s.irq_status_r;
			end
			OFS_IRQ_MASK: begin
				rd_word[IRQ_W-1:0] = s.irq_mask_r;
			end
			default: begin
				hit = 1'b0;
			end
		endcase
	end

	// Only an entry the host actually saw is removed
	assign silo_pop = rd_commit & (paddr == OFS_STATUS_REPORT) & s.nsr_seen_r;

	// ****************************************
	// Next state
	// ****************************************
	logic mclr;
	logic [15:0] sc;
	logic [IRQ_W-1:0] ev;

	always_comb begin
		s_nxt = s;
		mclr = 1'b0;
		sc = s.system_control_r;
		ev = '0;
		s_nxt.strobe_r = 1'b0;
		s_nxt.rx_clr_r = 1'b0;

		// APB handshake and read capture
		s_nxt.pready_r = in_access;
		s_nxt.pslverr_r = in_access & ~hit;
		if (in_access) begin
			s_nxt.prdata_r = {16'h0000, rd_word};
			s_nxt.irq_seen_r = s.irq_status_r;
			s_nxt.nsr_seen_r = ~silo_empty;
		end

		// System control write; bit 11 acts but is never stored
		if (wr_commit && paddr == OFS_SYSTEM_CONTROL) begin
			sc = (sc & ~SC_RW_MASK) | (pwdata[15:0] & SC_RW_MASK); // R3 R6
			if (s.system_control_r[SC_FLAG_WE]) begin
				sc[SC_ST_FLAG] = pwdata[SC_ST_FLAG]; // R9
				sc[SC_RX_FLAG] = pwdata[SC_RX_FLAG]; // R12
			end
			if (pwdata[SC_RX_DONE]) begin
				sc[SC_RX_FLAG] = 1'b0;
			end
			mclr = pwdata[SC_MCLR]; // R5
		end

		// Line control write; bit 15 strobes and clears itself
		if (wr_commit && paddr == OFS_LINE_CONTROL) begin
			s_nxt.line_control_r[LC_STORE_HI:LC_STORE_LO] = pwdata[LC_STORE_HI:LC_STORE_LO];
			s_nxt.strobe_r = pwdata[LC_STROBE];
		end

		// Select and mask registers
		if (wr_commit && paddr == OFS_SEC_REG_SELECT) begin
			s_nxt.srs_r = pwdata[15:0];
		end
		if (wr_commit && paddr == OFS_IRQ_MASK) begin
			s_nxt.irq_mask_r = pwdata[IRQ_W-1:0];
		end

		// Reading the status report drops its flag and any hidden top bit
		if (rd_commit && paddr == OFS_STATUS_REPORT) begin
			sc[SC_ST_FLAG] = 1'b0; // R8
			if (s.nsr_seen_r) begin
				s_nxt.nsr_hide_r = 1'b0;
			end
		end

		// Master clear
		if (mclr) begin
			sc = sc & ~SC_MCLR_MASK; // R4
			s_nxt.ric_r = REG_RESET; // R4
			s_nxt.line_control_r[LC_STORE_HI:LC_STORE_LO] = 8'h00; // R4
			s_nxt.nsr_hide_r = 1'b1; // R4
			s_nxt.rx_clr_r = 1'b1; // R5
		end

		// Receive character capture from the microprocessor
		if (ric_load) begin
			s_nxt.ric_r = ric_data;
		end

		// Hardware sets come last so they win over any clear
		if (status_push) begin
			sc[SC_ST_FLAG] = 1'b1; // R7
			ev[IRQ_ST] = 1'b1;
		end
		if (silo_full) begin
			ev[IRQ_OVF] = ~s.system_control_r[SC_OVF];
			sc[SC_OVF] = 1'b1; // R1
		end
		if (rx_int_set) begin
			sc[SC_RX_FLAG] = 1'b1;
			ev[IRQ_RX] = 1'b1;
		end
		s_nxt.system_control_r = sc;

		// Sticky interrupt status: read clears what was reported
		if (rd_commit && paddr == OFS_IRQ_STATUS) begin
			s_nxt.irq_status_r = s.irq_status_r & ~s.irq_seen_r;
		end
		s_nxt.irq_status_r = s_nxt.irq_status_r | ev;

		// Vector requests from the gated flags
		s_nxt.vec_a_r = sc[SC_RX_FLAG] & sc[SC_RX_IE];
		s_nxt.vec_b_r = (sc[SC_OVF] & sc[SC_OVF_IE]) // R2
			| (sc[SC_ST_FLAG] & sc[SC_ST_IE]); // R6 R13
		s_nxt.irq_r = |(s_nxt.irq_status_r & s_nxt.irq_mask_r);
	end

	// ****************************************
	// Registers
	// ****************************************

	// Initialize clears every control and flag bit
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			s <= '0; // R2 R3 R6 R8
			s.system_control_r <= REG_RESET;
			s.irq_status_r <= IRQ_RESET;
			s.irq_mask_r <= IRQ_RESET;
		end else begin
			s <= s_nxt;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign prdata = s.prdata_r;
	assign pready = s.pready_r;
	assign pslverr = s.pslverr_r;
	assign uproc_go = s.system_control_r[SC_GO];
	assign ext_addr_hi = s.system_control_r[SC_EXT_LO +: 2];
	assign line_ctrl_bits = s.line_control_r[LC_STORE_HI:LC_STORE_LO];
	assign line_strobe = s.strobe_r;
	assign rx_silo_clear = s.rx_clr_r;
	assign vector_a_req = s.vec_a_r;
	assign vector_b_req = s.vec_b_r;
	assign irq = s.irq_r;

endmodule : mux_ctrl_regs

`default_nettype wire

// file: bench/mux_ctrl_regs_asserts.sv
// Port checker for the control/status register bank.
// Assumes it is bound into mux_ctrl_regs and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
// ********
// Checker
// ********
module mux_ctrl_regs_asserts
	import mux_regs_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	// Block outputs
	input wire logic uproc_go,
	input wire logic [7:0] line_ctrl_bits,
	input wire logic rx_silo_clear,
	input wire logic vector_a_req,
	input wire logic vector_b_req,
	input wire logic irq
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	// Only the pready cycle completes a transfer
	wire logic acc = psel & penable & pready;
	wire logic rd0 = acc & !pwrite & (paddr == OFS_SYSTEM_CONTROL);
	wire logic wr0 = acc & pwrite & (paddr == OFS_SYSTEM_CONTROL);
	wire logic mc = wr0 & pwdata[SC_MCLR];
	wire logic rdl = acc & !pwrite & (paddr == OFS_LINE_CONTROL);
	wire logic off = wr0 & !pwdata[SC_OVF_IE] & !pwdata[SC_ST_IE];
	// Master clear effects
	property p_mclr_pulse; mc |=> rx_silo_clear ##1 !rx_silo_clear; endproperty
	a_mclr_pulse: assert property (p_mclr_pulse) else $error("clear pulse missing");
	property p_mclr_cause; rx_silo_clear |-> $past(mc); endproperty
	a_mclr_cause: assert property (p_mclr_cause) else $error("stray clear pulse");
	property p_mclr_bits; mc |=> line_ctrl_bits == 8'h00 && !uproc_go; endproperty
	a_mclr_bits: assert property (p_mclr_bits) else $error("bits kept by clear");
	property p_mclr_self; rd0 |-> !prdata[SC_MCLR]; endproperty
	a_mclr_self: assert property (p_mclr_self) else $error("clear bit reads one");
	// Read-only display and gated requests
	property p_lc_ro; rdl |-> (prdata & 32'hffffffcf) == 32'h0; endproperty
	a_lc_ro: assert property (p_lc_ro) else $error("line control extra bits");
	property p_vb_gate;
		rd0 |-> vector_b_req == (prdata[SC_OVF] & prdata[SC_OVF_IE]
			| prdata[SC_ST_FLAG] & prdata[SC_ST_IE]);
	endproperty
	a_vb_gate: assert property (p_vb_gate) else $error("vector b mismatch");
	property p_ie_off; off |-> ##2 !vector_b_req; endproperty
	a_ie_off: assert property (p_ie_off) else $error("vector b while disabled");
	property p_va_gate; rd0 |-> vector_a_req == (prdata[SC_RX_FLAG] & prdata[SC_RX_IE]); endproperty
	a_va_gate: assert property (p_va_gate) else $error("vector a mismatch");
	// Main scenarios reached
	c_mclr: cover property (mc);
	c_vb: cover property (vector_b_req);
	c_irq: cover property (irq);
endmodule : mux_ctrl_regs_asserts
bind mux_ctrl_regs mux_ctrl_regs_asserts chk (.sys_clk, .reset, .psel, .penable, .pwrite,
	.paddr, .pwdata, .prdata, .pready, .uproc_go, .line_ctrl_bits, .rx_silo_clear,
	.vector_a_req, .vector_b_req, .irq);
`default_nettype wire

// file: bench/uproc_model.sv
// Model of the internal microprocessor that feeds the register bank.
// Assumes the bench calls ev; each strobe lasts one cycle.
`timescale 1ns/100ps
`default_nettype none
// ********
// Microprocessor model
// ********
module uproc_model (
	// Clock
	input wire logic sys_clk,
	// Strobes and data to the bank
	output logic status_push,
	output logic [15:0] status_data,
	output logic rx_int_set,
	output logic ric_load,
	output logic [15:0] ric_data,
	output logic ext_wr,
	output logic [3:0] ext_wr_line,
	output logic [3:0] ext_wr_reg,
	output logic [1:0] ext_wr_bits
);
	// Quiet at time zero
	initial begin
		{status_push, rx_int_set, ric_load, ext_wr} = 4'h0;
		{status_data, ric_data, ext_wr_bits, ext_wr_reg, ext_wr_line} = 42'h0;
	end
	// One event per call; data turns over on release so stale values never match
	task automatic ev(input logic [1:0] k, input logic [15:0] d);
		@(posedge sys_clk);
		status_push <= (k == 2'h0);
		rx_int_set <= (k == 2'h1);
		ric_load <= (k == 2'h2);
		ext_wr <= (k == 2'h3);
		{status_data, ric_data} <= {d, d};
		{ext_wr_bits, ext_wr_reg, ext_wr_line} <= d[9:0];
		@(posedge sys_clk);
		{status_push, rx_int_set, ric_load, ext_wr} <= 4'h0;
		{status_data, ric_data} <= ~{d, d};
		{ext_wr_bits, ext_wr_reg, ext_wr_line} <= ~d[9:0];
	endtask : ev
endmodule : uproc_model
`default_nettype wire

// file: bench/mux_system_control_status_regs_tb.sv
// Self-checking bench of the control/status register bank.
// Assumes the bank, its checker and the microprocessor model compile first.
`timescale 1ns/100ps
`default_nettype none
// ********
// Bench
// ********
module mux_system_control_status_regs_tb
	import mux_regs_pkg::*;
;
	logic sys_clk = 1'b0;
	logic reset = 1'b1;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [31:0] pwdata = '0;
	wire logic [31:0] prdata;
	wire logic pready, pslverr, uproc_go, line_strobe, rx_silo_clear;
	wire logic vector_a_req, vector_b_req, irq, status_push, rx_int_set, ric_load, ext_wr;
	wire logic [1:0] ext_addr_hi, ext_wr_bits;
	wire logic [7:0] line_ctrl_bits;
	wire logic [15:0] status_data, ric_data;
	wire logic [3:0] ext_wr_line, ext_wr_reg;
	int fails = 0;
	int checked = 0;
	logic [32:0] expq[$];
	logic [15:0] sq[$];
	logic [15:0] d;
	logic [7:0] lc;
	// Clock
	always #5 sys_clk = ~sys_clk;
	// Block and its partner
	mux_ctrl_regs DUT (.sys_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .status_push, .status_data, .rx_int_set, .ric_load,
		.ric_data, .ext_wr, .ext_wr_line, .ext_wr_reg, .ext_wr_bits, .uproc_go,
		.ext_addr_hi, .line_ctrl_bits, .line_strobe, .rx_silo_clear, .vector_a_req,
		.vector_b_req, .irq);
	uproc_model up (.sys_clk, .status_push, .status_data, .rx_int_set, .ric_load,
		.ric_data, .ext_wr, .ext_wr_line, .ext_wr_reg, .ext_wr_bits);
	task automatic chk(input string n, input logic [32:0] e, input logic [32:0] g);
		checked++;
		if (g !== e) begin
			fails++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	// Scoreboard: looked at mid-cycle, where pready and prdata have settled
	always @(negedge sys_clk) begin
		if (psel && penable && pready === 1'b1 && !pwrite)
			chk("prdata", expq.pop_front(), {pslverr, prdata});
	end
	// One APB transfer; read notes go in at setup so order is kept
	// The request stands until pready is seen high at a rising edge; only the watchdog
	// ends a wait that never completes
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v,
		input logic [32:0] e);
		@(posedge sys_clk);
		{psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, v};
		if (!w)
			expq.push_back(e);
		@(posedge sys_clk);
		penable <= 1'b1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		{psel, penable} <= 2'h0;
	endtask : apb
	task automatic rd(input logic [7:0] a, input logic [15:0] v);
		apb(1'b0, a, 32'h0, {17'h0, v});
	endtask : rd
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		apb(1'b1, a, v, 33'h0);
	endtask : wr
	task automatic tick(input int k);
		repeat (k) @(negedge sys_clk);
	endtask : tick
	task automatic summarize;
		$display("Checks %0d, mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : summarize
	// Watchdog: the run needs about 600 cycles
	initial begin
		#200000;
		fails++;
		summarize();
	end
	// Main sequence
	initial begin
		void'($urandom(32'h9739cec9));
		repeat (12) @(posedge sys_clk);
		reset <= 1'b0;
		for (int i = 0; i < 7; i++) rd(8'(4 * i), 16'h0);
		apb(1'b0, 8'h1c, 32'h0, {1'b1, 32'h0});
		// Extended address bits follow the select register
		repeat (3) begin
			d = 16'($urandom) & 16'h03ff;
			up.ev(2'h3, d);
			wr(OFS_SEC_REG_SELECT, {20'h0, d[7:4], 4'h0, d[3:0]});
			rd(OFS_LINE_CONTROL, {10'h0, d[9:8], 4'h0});
		end
		lc = 8'($urandom);
		wr(OFS_LINE_CONTROL, {16'h0, 1'b1, lc, 7'h0});
		tick(1);
		chk("line_strobe", 1, line_strobe);
		tick(1);
		chk("line_strobe", 0, line_strobe);
		chk("line_ctrl_bits", lc, line_ctrl_bits);
		d = 16'($urandom);
		up.ev(2'h2, d);
		rd(OFS_RX_INT_CHAR, d);
		// Status entry: masked, unmasked, cleared by reading
		up.ev(2'h0, d);
		tick(2);
		chk("irq", 0, irq);
		wr(OFS_IRQ_MASK, 32'h7);
		tick(2);
		chk("irq", 1, irq);
		rd(OFS_IRQ_STATUS, 16'h1);
		tick(2);
		chk("irq", 0, irq);
		wr(OFS_SYSTEM_CONTROL, 32'h2000);
		tick(2);
		chk("vector_b_req", 1, vector_b_req);
		rd(OFS_SYSTEM_CONTROL, 16'ha000);
		rd(OFS_STATUS_REPORT, d);
		rd(OFS_SYSTEM_CONTROL, 16'h2000);
		// Flags take host writes only once the write enable is already set
		wr(OFS_SYSTEM_CONTROL, 32'ha080);
		rd(OFS_SYSTEM_CONTROL, 16'h2000);
		wr(OFS_SYSTEM_CONTROL, 32'h2200);
		wr(OFS_SYSTEM_CONTROL, 32'ha280);
		rd(OFS_SYSTEM_CONTROL, 16'ha280);
		wr(OFS_SYSTEM_CONTROL, 32'h0);
		// Go and extended address bits reach their pins
		wr(OFS_SYSTEM_CONTROL, 32'h0031);
		tick(2);
		chk("ext_addr_hi", 3, ext_addr_hi);
		chk("uproc_go", 1, uproc_go);
		// Fill the status silo to overflow, then master clear
		wr(OFS_SYSTEM_CONTROL, 32'h1041);
		up.ev(2'h1, 16'h0);
		repeat (64) begin
			if (sq.size() == 63)
				rd(OFS_SYSTEM_CONTROL, 16'h90c1);
			d = 16'($urandom);
			sq.push_back(d);
			up.ev(2'h0, d);
		end
		rd(OFS_SYSTEM_CONTROL, 16'h94c1);
		tick(1);
		chk("vector_b_req", 1, vector_b_req);
		chk("irq", 1, irq);
		rd(OFS_IRQ_STATUS, 16'h7);
		wr(OFS_SYSTEM_CONTROL, 32'h0800);
		rd(OFS_SYSTEM_CONTROL, 16'h0400);
		tick(1);
		chk("vector_b_req", 0, vector_b_req);
		rd(OFS_RX_INT_CHAR, 16'h0);
		rd(OFS_STATUS_REPORT, sq.pop_front() & 16'h7fff);
		while (sq.size() > 0) rd(OFS_STATUS_REPORT, sq.pop_front());
		rd(OFS_STATUS_REPORT, 16'h0);
		summarize();
	end
endmodule : mux_system_control_status_regs_tb
`default_nettype wire
